// File: rrx_pkg.sv
package rrx_pkg;
  // ----------------------------------------
  // Instruction encodings (14-bit words)
  // ----------------------------------------
  localparam logic [13:0] RRX_OP_RET_INT = 14'h0009;
  localparam logic [13:0] RRX_OP_RET_SUB = 14'h0008;
  localparam logic [13:0] RRX_RET_LIT_MASK = 14'h3C00;
  localparam logic [13:0] RRX_RET_LIT_CODE = 14'h3400;
  localparam logic [13:0] RRX_ROT_MASK = 14'h3F00;
  localparam logic [13:0] RRX_ROT_CODE = 14'h0D00;
  localparam int RRX_DEST_BIT = 7;
  localparam int RRX_FADDR_MSB = 6;
  localparam int RRX_GLOBAL_INT_EN_BIT = 7;
  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int RRX_PC_W = 13;
  localparam logic [12:0] RRX_PC_RST = 13'h0000;
  localparam logic [7:0] RRX_BYTE_RST = 8'h00;
  localparam logic [6:0] RRX_FADDR_RST = 7'h00;
  typedef enum {RRX_EXEC, RRX_FLUSH} rrx_state_e;
endpackage

// File: rrx_exec.sv
`timescale 1ns/1ps
`default_nettype none
module rrx_exec (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  // Instruction from decode, valid each cycle when set
  input wire logic I_INSTR_VALID,
  input wire logic [13:0] I_INSTR,
  // Operands from the core
  input wire logic [rrx_pkg::RRX_PC_W-1:0] I_TOP_OF_STACK,
  input wire logic [7:0] I_FILE_RDATA,
  input wire logic I_CARRY,
  input wire logic [7:0] I_INTCTL,
  // Results toward the core
  output logic O_STACK_POP,
  output logic O_PC_LOAD,
  output logic [rrx_pkg::RRX_PC_W-1:0] O_PC,
  output logic O_W_WE,
  output logic [7:0] O_W,
  output logic O_FILE_WE,
  output logic [6:0] O_FILE_ADDR,
  output logic [7:0] O_FILE_WDATA,
  output logic O_CARRY_WE,
  output logic O_CARRY,
  output logic O_INTCTL_WE,
  output logic [7:0] O_INTCTL,
  output logic O_BUSY
);
  import rrx_pkg::*;

  // ----------------------------------------
  // Decode helper
  // ----------------------------------------
  function automatic logic rrx_match(input logic [13:0] w, input logic [13:0] m, input logic [13:0] c);
    rrx_match = (w & m) == c;
  endfunction

  // Sequencer state and the registered copies of every output
  rrx_state_e state_reg, state_next;
  logic pop_reg, pop_next, pcld_reg, pcld_next;
  logic [RRX_PC_W-1:0] pc_reg, pc_next;
  logic wwe_reg, wwe_next, fwe_reg, fwe_next, cwe_reg, cwe_next, c_reg, c_next;
  logic [7:0] w_reg, w_next, fd_reg, fd_next, ic_reg, ic_next;
  logic [6:0] fa_reg, fa_next;
  logic icwe_reg, icwe_next;
  // Busy has its own flop so that the output is not a decode of the state
  logic busy_reg, busy_next;
  // Decoded opcode classes and the rotated operand
  logic is_rti, is_ret, is_ret_lit, is_rot;
  logic [7:0] rot;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Returns need a flushed second cycle because the fetched word is stale.
  always_comb begin
    is_rti = rrx_match(I_INSTR, 14'h3FFF, RRX_OP_RET_INT);
    is_ret = rrx_match(I_INSTR, 14'h3FFF, RRX_OP_RET_SUB);
    is_ret_lit = rrx_match(I_INSTR, RRX_RET_LIT_MASK, RRX_RET_LIT_CODE);
    is_rot = rrx_match(I_INSTR, RRX_ROT_MASK, RRX_ROT_CODE);
    rot = {I_FILE_RDATA[6:0], I_CARRY};
    state_next = RRX_EXEC;
    pop_next = 1'b0;
    pcld_next = 1'b0;
    pc_next = pc_reg;
    wwe_next = 1'b0;
    w_next = w_reg;
    fwe_next = 1'b0;
    fa_next = fa_reg;
    fd_next = fd_reg;
    cwe_next = 1'b0;
    c_next = c_reg;
    icwe_next = 1'b0;
    ic_next = ic_reg;
    busy_next = 1'b0;
    case (state_reg)
      RRX_EXEC: begin
        if (I_INSTR_VALID && (is_rti || is_ret || is_ret_lit)) begin
          pop_next = 1'b1;
          pcld_next = 1'b1;
          pc_next = I_TOP_OF_STACK;
          state_next = RRX_FLUSH;
          busy_next = 1'b1;
          if (is_rti) begin
            icwe_next = 1'b1;
            // Read-modify-write keeps the other interrupt control bits intact
            ic_next = I_INTCTL | (8'h01 << RRX_GLOBAL_INT_EN_BIT);
          end
          if (is_ret_lit) begin
            wwe_next = 1'b1;
            w_next = I_INSTR[7:0];
          end
        end else if (I_INSTR_VALID && is_rot) begin
          // Carry is written back whichever destination takes the result
          cwe_next = 1'b1;
          c_next = I_FILE_RDATA[7];
          fa_next = I_INSTR[RRX_FADDR_MSB:0];
          if (I_INSTR[RRX_DEST_BIT]) begin
            fwe_next = 1'b1;
            fd_next = rot;
          end else begin
            wwe_next = 1'b1;
            w_next = rot;
          end
        end
      end
      RRX_FLUSH: state_next = RRX_EXEC;
      default: state_next = RRX_EXEC;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= RRX_EXEC;
      pop_reg <= 1'b0;
      pcld_reg <= 1'b0;
      pc_reg <= RRX_PC_RST;
      wwe_reg <= 1'b0;
      w_reg <= RRX_BYTE_RST;
      fwe_reg <= 1'b0;
      fa_reg <= RRX_FADDR_RST;
      fd_reg <= RRX_BYTE_RST;
      cwe_reg <= 1'b0;
      c_reg <= 1'b0;
      icwe_reg <= 1'b0;
      ic_reg <= RRX_BYTE_RST;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pop_reg <= pop_next;
      pcld_reg <= pcld_next;
      pc_reg <= pc_next;
      wwe_reg <= wwe_next;
      w_reg <= w_next;
      fwe_reg <= fwe_next;
      fa_reg <= fa_next;
      fd_reg <= fd_next;
      cwe_reg <= cwe_next;
      c_reg <= c_next;
      icwe_reg <= icwe_next;
      ic_reg <= ic_next;
      busy_reg <= busy_next;
    end
  end

  // Every output is a flop, so the core never sees decode glitches
  assign O_STACK_POP = pop_reg;
  assign O_PC_LOAD = pcld_reg;
  assign O_PC = pc_reg;
  assign O_W_WE = wwe_reg;
  assign O_W = w_reg;
  assign O_FILE_WE = fwe_reg;
  assign O_FILE_ADDR = fa_reg;
  assign O_FILE_WDATA = fd_reg;
  assign O_CARRY_WE = cwe_reg;
  assign O_CARRY = c_reg;
  assign O_INTCTL_WE = icwe_reg;
  assign O_INTCTL = ic_reg;
  assign O_BUSY = busy_reg; // Second cycle of a return

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Words are taken only in the execute state; one offered in the flush
  // cycle must leave no trace on any output.
  sequence s_ret_take;
    state_reg == RRX_EXEC && I_INSTR_VALID && (is_rti || is_ret || is_ret_lit);
  endsequence
  sequence s_rti_take;
    state_reg == RRX_EXEC && I_INSTR_VALID && is_rti;
  endsequence
  sequence s_ret_lit_take;
    state_reg == RRX_EXEC && I_INSTR_VALID && is_ret_lit;
  endsequence
  sequence s_ret_sub_take;
    state_reg == RRX_EXEC && I_INSTR_VALID && is_ret;
  endsequence
  sequence s_rot_take;
    state_reg == RRX_EXEC && I_INSTR_VALID && is_rot;
  endsequence
  // Flush cycle of a return, then back to execute
  sequence s_flush_then_exec;
    O_BUSY ##1 !O_BUSY;
  endsequence
  property p_pop_pc;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      s_ret_take |=> O_STACK_POP && O_PC_LOAD && O_PC == $past(I_TOP_OF_STACK);
  endproperty
  ret_pops_pc_a: assert property (p_pop_pc) else $error("return did not pop into PC");
  rti_int_en_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_rti_take |=> O_INTCTL_WE && O_INTCTL[RRX_GLOBAL_INT_EN_BIT] && !O_CARRY_WE)
    else $error("interrupt enable not set");
  rti_keep_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_rti_take |=> O_INTCTL[6:0] == $past(I_INTCTL[6:0])) else $error("other control bits changed");
  ret_two_cyc_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_ret_take |=> s_flush_then_exec) else $error("return not two cycles");
  flush_quiet_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (state_reg == RRX_FLUSH) |=> !O_STACK_POP && !O_PC_LOAD && !O_W_WE && !O_FILE_WE && !O_CARRY_WE
    && !O_INTCTL_WE) else $error("word taken in flush cycle");
  ret_lit_w_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_ret_lit_take |=> O_W_WE && O_W == $past(I_INSTR[7:0])) else $error("literal not in W");
  ret_lit_flags_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_ret_lit_take |=> !O_CARRY_WE && !O_INTCTL_WE && !O_FILE_WE) else $error("literal return changed flags");
  ret_plain_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_ret_sub_take |=> !O_W_WE && !O_INTCTL_WE && !O_CARRY_WE && !O_FILE_WE) else $error("return changed state");
  rot_res_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_rot_take |=> O_CARRY_WE && O_CARRY == $past(I_FILE_RDATA[7])
    && (O_FILE_WE ? O_FILE_WDATA : O_W) == {$past(I_FILE_RDATA[6:0]), $past(I_CARRY)})
    else $error("rotate result wrong");
  rot_dest_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_rot_take |=> O_FILE_WE == $past(I_INSTR[RRX_DEST_BIT]) && O_FILE_ADDR == $past(I_INSTR[RRX_FADDR_MSB:0]))
    else $error("rotate destination wrong");
  rot_one_cyc_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_rot_take |=> !O_BUSY && !O_STACK_POP && !O_PC_LOAD && !O_INTCTL_WE && (O_FILE_WE != O_W_WE))
    else $error("rotate not single cycle");
endmodule
`default_nettype wire

// File: return_and_rotate_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
module return_and_rotate_exec_test;
  import rrx_pkg::*;
  logic clk = 0, rst_n = 0, valid = 0, cy = 0;
  logic [13:0] instr = 14'h0000;
  logic [13:0] word = 14'h0000;
  logic [12:0] top_of_stack = 13'h0000;
  logic [7:0] frd = 8'h00, ictl = 8'h00;
  logic pop, pcl, wwe, fwe, cwe, co, iwe, busy;
  logic [12:0] pc;
  logic [7:0] w, fwd, io;
  logic [6:0] fa;
  int failures = 0, n_compared = 0, seed = 73243, i, r;
  bit busy_exp = 0;
  rrx_exec rrx_exec_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_INSTR_VALID(valid), .I_INSTR(instr),
    .I_TOP_OF_STACK(top_of_stack),
    .I_FILE_RDATA(frd), .I_CARRY(cy), .I_INTCTL(ictl), .O_STACK_POP(pop), .O_PC_LOAD(pcl), .O_PC(pc),
    .O_W_WE(wwe), .O_W(w), .O_FILE_WE(fwe), .O_FILE_ADDR(fa), .O_FILE_WDATA(fwd), .O_CARRY_WE(cwe),
    .O_CARRY(co), .O_INTCTL_WE(iwe), .O_INTCTL(io), .O_BUSY(busy));
  // ----------------------------------------
  // Clock, checks and verdict
  // ----------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input bit bad, input string msg);
    n_compared++;
    if (bad) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Expected rotate result: old bit 7 leaves, old carry enters bit 0
  function automatic logic [7:0] exp_rot(input logic [7:0] f, input logic c);
    return {f[6:0], c};
  endfunction
  // Drives one word at a falling edge, checks the answer at the next falling edge
  task automatic step(input logic [13:0] ins, input logic v);
    bit ok, ri, rs, lt, rt, rets;
    logic [7:0] rot;
    valid = v;
    instr = ins;
    top_of_stack = 13'($random(seed));
    frd = 8'($random(seed));
    cy = 1'($random(seed));
    ictl = 8'($random(seed));
    @(negedge clk);
    // A word presented during the flush cycle must be ignored
    ok = v && !busy_exp;
    ri = ins == RRX_OP_RET_INT;
    rs = ins == RRX_OP_RET_SUB;
    lt = (ins & RRX_RET_LIT_MASK) == RRX_RET_LIT_CODE;
    rt = (ins & RRX_ROT_MASK) == RRX_ROT_CODE;
    rets = ok && (ri || rs || lt);
    rot = exp_rot(frd, cy);
    chk({pop, pcl, wwe, fwe, cwe, iwe, busy} !== {rets, rets, ok && (lt || rt && !ins[7]), ok && rt && ins[7],
      ok && rt, ok && ri, rets}, "strobes");
    if (rets) chk(pc !== top_of_stack, "pc");
    if (ok && ri) chk(io !== (ictl | 8'h80), "intctl");
    if (ok && lt) chk(w !== ins[7:0], "literal");
    if (ok && rt) chk(co !== frd[7], "carry");
    if (ok && rt && !ins[7]) chk(w !== rot, "rot w");
    if (ok && rt && ins[7]) chk({fa, fwd} !== {ins[6:0], rot}, "rot f");
    busy_exp = rets;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    chk({pop, pcl, pc, wwe, w, fwe, fa, fwd, cwe, co, iwe, io, busy} !== '0, "reset");
    rst_n = 1;
    // Returns back to back, so the second lands in the flush cycle
    step(RRX_OP_RET_INT, 1);
    step(RRX_OP_RET_SUB, 1);
    step(14'h34FF, 1);
    step(14'h3700, 1);
    step(RRX_OP_RET_SUB, 1);
    step(14'h0D85, 1);
    step(14'h0D7F, 1);
    step(14'h0D85, 1);
    step(14'h0000, 1);
    step(RRX_OP_RET_INT, 0);
    // Reset in the flush cycle of a return clears every output at once
    step(RRX_OP_RET_SUB, 1);
    rst_n = 0;
    @(negedge clk);
    chk({pop, pcl, pc, wwe, w, fwe, fa, fwd, cwe, co, iwe, io, busy} !== '0, "mid reset");
    rst_n = 1;
    busy_exp = 0;
    step(14'h3700, 1);
    step(14'h0D85, 1);
    $display("corner cases done");
    for (i = 0; i < 400; i++) begin
      r = $random(seed);
      word = r[13:0];
      case (r[17:16])
        2'd0: word = (word & ~RRX_RET_LIT_MASK) | RRX_RET_LIT_CODE;
        2'd1: word = (word & ~RRX_ROT_MASK) | RRX_ROT_CODE;
        2'd2: word = r[18] ? RRX_OP_RET_INT : RRX_OP_RET_SUB;
        default: word = r[13:0];
      endcase
      step(word, r[20] | r[21]);
    end
    $display("random mix done");
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
